// [inc/tsp_link_if.sv]
// two-wire link between the touch sensor port and its host
// assumes open-drain enables are low while a party pulls low
interface tsp_link_if;

  logic host_scl_oe_n;
  logic host_sda_oe_n;
  logic dev_sda_oe_n;
  logic dev_alert_oe_n;
  logic scl;
  logic sda;
  logic alert_n;

  // ************************************************************
  // wired-and resolution with pull-ups
  // ************************************************************
  assign scl     = host_scl_oe_n;
  assign sda     = host_sda_oe_n & dev_sda_oe_n;
  assign alert_n = dev_alert_oe_n;

  modport dev (
    input  scl,
    input  sda,
    output dev_sda_oe_n,
    output dev_alert_oe_n
  );

  modport host (
    output host_scl_oe_n,
    output host_sda_oe_n,
    input  scl,
    input  sda,
    input  alert_n
  );

endinterface

// [inc/tsp_pkg.sv]
// shared constants and types for the touch sensor two-wire port
// assumes both ends and the link checker import this package
package tsp_pkg;

  // ************************************************************
  // device addressing and register space
  // ************************************************************
  localparam logic [6:0] TSP_SLAVE_ADDR = 7'h4a;
  localparam int         TSP_NREG       = 16;
  localparam int         TSP_IDX_W      = 4;
  localparam logic [7:0] TSP_STATUS_REG = 8'h00;
  localparam logic [7:0] TSP_REG_RST    = 8'h00;
  localparam logic [7:0] TSP_PTR_RST    = 8'h00;

  // ************************************************************
  // write stream buffer
  // ************************************************************
  localparam int TSP_FIFO_W     = 16;
  localparam int TSP_FIFO_DEPTH = 16;

  // ************************************************************
  // bit timing of the host end
  // ************************************************************
  localparam int TSP_MCLK_KHZ = 125000;
  localparam int TSP_BIT_KBPS = 400;
  // quarter bit, rounded up so the rate never exceeds the limit
  localparam int TSP_QTR_CYC  =
    (TSP_MCLK_KHZ + 4 * TSP_BIT_KBPS - 1) / (4 * TSP_BIT_KBPS);
  localparam logic [6:0] TSP_QTR_LAST = 7'(TSP_QTR_CYC - 1);

  // ************************************************************
  // bit counter codes
  // ************************************************************
  localparam logic [3:0] TSP_CNT_PRE  = 4'hf;
  localparam logic [3:0] TSP_CNT_LAST = 4'h7;
  localparam logic [3:0] TSP_CNT_ACK  = 4'h8;

  typedef enum logic [2:0] {
    D_IDLE  = 3'b000,
    D_ADDR  = 3'b001,
    D_PTR   = 3'b011,
    D_WDATA = 3'b010,
    D_RDATA = 3'b110
  } tsp_dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_START = 2'b01,
    H_BITS  = 2'b11,
    H_STOP  = 2'b10
  } tsp_host_state_t;

endpackage

// [src/tsp_device.sv]
// touch sensor two-wire slave end with its write stream buffer
// assumes a link clock far faster than the bit rate, and a user
// side on i_mclk that supplies pad status and drains writes
//
// What this block does
// [RULE_01] master starts transfers and makes the clock
// [RULE_02] data line sampled, only ever pulled low
// [RULE_03] clock line is input only, no stretching
// [RULE_04] start, address, pointer, data bytes, stop
// [RULE_05] released lines mean idle bus
// [RULE_06] data falling while clock high is start
// [RULE_07] data rising while clock high is stop
// [RULE_08] one bit per clock pulse, counted
// [RULE_09] data changes only while clock low
// [RULE_10] alert pulled low on pad status change
// [RULE_11] alert use leaves only two pads
// [RULE_12] bit rates up to 400 kbit/s
// [RULE_13] ninth clock carries the receiver acknowledge
// [RULE_14] eighth bit high reads, low writes
// [RULE_15] first written byte becomes register pointer
// [RULE_16] pointer advances after each data byte
// [RULE_17] any start restarts address reception

// ************************************************************
// dual clock buffer with gray pointers and registered output
// ************************************************************
module tsp_fifo
  import tsp_pkg::*;
#(
  parameter int W     = TSP_FIFO_W,
  parameter int DEPTH = TSP_FIFO_DEPTH
) (
  input  wire logic         i_wclk,
  input  wire logic         i_wrst_n,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_rclk,
  input  wire logic         i_rrst_n,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic      [W-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wbin_q, rbin_q, wgray_q, rgray_q;
  logic [AW:0]  rg_m_q, rg_s_q, wg_m_q, wg_s_q;
  logic [AW:0]  wbin_d, rbin_d;
  logic         full, empty, push, pull;

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // full and empty from the other side's synchronised pointer
  assign full  = wgray_q == {~rg_s_q[AW:AW-1], rg_s_q[AW-2:0]};
  assign empty = rgray_q == wg_s_q;
  assign o_ready = ~full;
  assign push  = i_valid & ~full;
  assign pull  = ~empty & (~o_valid | i_ready);
  assign wbin_d = wbin_q + (AW+1)'(1);
  assign rbin_d = rbin_q + (AW+1)'(1);

  // write side
  always_ff @(posedge i_wclk) begin
    if (!i_wrst_n) begin
      wbin_q  <= '0;
      wgray_q <= '0;
    end else if (push) begin
      mem_q[wbin_q[AW-1:0]] <= i_data;
      wbin_q  <= wbin_d;
      wgray_q <= bin2gray(wbin_d);
    end
  end

  // read pointer into the write domain
  always_ff @(posedge i_wclk) begin
    if (!i_wrst_n) begin
      rg_m_q <= '0;
      rg_s_q <= '0;
    end else begin
      rg_m_q <= rgray_q;
      rg_s_q <= rg_m_q;
    end
  end

  // write pointer into the read domain
  always_ff @(posedge i_rclk) begin
    if (!i_rrst_n) begin
      wg_m_q <= '0;
      wg_s_q <= '0;
    end else begin
      wg_m_q <= wgray_q;
      wg_s_q <= wg_m_q;
    end
  end

  // read side with output register
  always_ff @(posedge i_rclk) begin
    if (!i_rrst_n) begin
      rbin_q  <= '0;
      rgray_q <= '0;
      o_valid <= 1'b0;
      o_data  <= '0;
    end else if (pull) begin
      o_data  <= mem_q[rbin_q[AW-1:0]];
      o_valid <= 1'b1;
      rbin_q  <= rbin_d;
      rgray_q <= bin2gray(rbin_d);
    end else if (i_ready) begin
      o_valid <= 1'b0;
    end
  end
endmodule

// ************************************************************
// slave end
// ************************************************************
module tsp_device
  import tsp_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_lclk,
  input  wire logic       i_lrst_n,
  tsp_link_if.dev         link,
  input  wire logic [2:0] i_pad_status,
  input  wire logic       i_alert_en,
  output logic            o_wr_valid,
  input  wire logic       i_wr_ready,
  output logic      [7:0] o_wr_addr,
  output logic      [7:0] o_wr_data
);
  tsp_dev_state_t state_q;
  logic [3:0]     cnt_q;
  logic [7:0]     rx_q, tx_q, ptr_q, rd_byte;
  logic           sda_oe_n_q, alert_oe_n_q, alert_q;
  logic [7:0]     regs_q [TSP_NREG];
  logic           scl_m_q, scl_s_q, scl_p_q;
  logic           sda_m_q, sda_s_q, sda_p_q;
  logic [2:0]     pad_m_q, pad_s_q, stat_q;
  logic           aen_m_q, aen_s_q;
  logic           scl_rise, scl_fall, start_det, stop_det;
  logic [2:0]     stat_now;
  logic           fifo_ready, push;
  logic [15:0]    fifo_out;

  function automatic logic [7:0] reg_read(input logic [7:0] p);
    return (p == TSP_STATUS_REG) ? {5'h00, stat_q}
                                 : regs_q[p[TSP_IDX_W-1:0]];
  endfunction

  // ************************************************************
  // pin synchronisers on the link clock
  // ************************************************************
  // scl only ever observed here, never driven  (see [RULE_03])
  always_ff @(posedge i_lclk) begin
    if (!i_lrst_n) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;  // released lines  (see [RULE_05])
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end else begin
      scl_m_q <= link.scl;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= link.sda;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  // pad status and alert mode cross as levels
  always_ff @(posedge i_lclk) begin
    if (!i_lrst_n) begin
      pad_m_q <= 3'h0;
      pad_s_q <= 3'h0;
      aen_m_q <= 1'b0;
      aen_s_q <= 1'b0;
    end else begin
      pad_m_q <= i_pad_status;
      pad_s_q <= pad_m_q;
      aen_m_q <= i_alert_en;
      aen_s_q <= aen_m_q;
    end
  end

  // bus conditions; data moves only with clock low  (see [RULE_09])
  assign scl_rise  = scl_s_q & ~scl_p_q;
  assign scl_fall  = ~scl_s_q & scl_p_q;
  assign start_det = scl_s_q & scl_p_q & ~sda_s_q & sda_p_q; // see [RULE_06]
  assign stop_det  = scl_s_q & scl_p_q & sda_s_q & ~sda_p_q; // see [RULE_07]
  // third pad dropped when its pin carries the alert  (see [RULE_11])
  assign stat_now  = {pad_s_q[2] & ~aen_s_q, pad_s_q[1:0]};
  assign rd_byte   = reg_read(ptr_q);
  assign push = scl_fall & (cnt_q == TSP_CNT_LAST) & (state_q == D_WDATA)
              & fifo_ready;

  // ************************************************************
  // byte engine, timed by the master clock pulses  (see [RULE_01])
  // ************************************************************
  always_ff @(posedge i_lclk) begin
    if (!i_lrst_n) begin
      state_q    <= D_IDLE;
      cnt_q      <= TSP_CNT_PRE;
      rx_q       <= 8'h00;
      tx_q       <= 8'h00;
      ptr_q      <= TSP_PTR_RST;
      sda_oe_n_q <= 1'b1;
    end else if (start_det) begin
      state_q    <= D_ADDR;                 // see [RULE_17]
      cnt_q      <= TSP_CNT_PRE;
      sda_oe_n_q <= 1'b1;
    end else if (stop_det) begin
      state_q    <= D_IDLE;                 // see [RULE_07]
      sda_oe_n_q <= 1'b1;
    end else if (state_q != D_IDLE) begin
      // one bit sampled per rising clock  (see [RULE_08])
      if (scl_rise && cnt_q < TSP_CNT_ACK && state_q != D_RDATA)
        rx_q <= {rx_q[6:0], sda_s_q};
      // master refusal ends the read burst  (see [RULE_13])
      if (scl_rise && cnt_q == TSP_CNT_ACK && state_q == D_RDATA &&
          sda_s_q)
        state_q <= D_IDLE;
      if (scl_fall) begin
        unique case (cnt_q)
          TSP_CNT_LAST: begin
            cnt_q      <= TSP_CNT_ACK;
            sda_oe_n_q <= 1'b1;
            unique case (state_q)
              D_ADDR: begin
                if (rx_q[7:1] == TSP_SLAVE_ADDR) begin
                  sda_oe_n_q <= 1'b0;            // see [RULE_13]
                  state_q    <= rx_q[0] ? D_RDATA : D_PTR; // see [RULE_14]
                end else begin
                  state_q <= D_IDLE;
                end
              end
              D_PTR: begin
                ptr_q      <= rx_q;              // see [RULE_15]
                sda_oe_n_q <= 1'b0;
                state_q    <= D_WDATA;
              end
              D_WDATA: begin
                // a full buffer refuses the byte
                if (fifo_ready) begin
                  ptr_q      <= ptr_q + 8'h01;   // see [RULE_16]
                  sda_oe_n_q <= 1'b0;
                end
              end
              default: ;
            endcase
          end
          TSP_CNT_ACK: begin
            cnt_q      <= 4'h0;
            sda_oe_n_q <= 1'b1;
            if (state_q == D_RDATA) begin
              tx_q       <= {rd_byte[6:0], 1'b0};
              sda_oe_n_q <= rd_byte[7];          // see [RULE_02]
              ptr_q      <= ptr_q + 8'h01;       // see [RULE_16]
            end
          end
          default: begin
            cnt_q <= cnt_q + 4'h1;
            if (state_q == D_RDATA && cnt_q != TSP_CNT_PRE) begin
              sda_oe_n_q <= tx_q[7];
              tx_q       <= {tx_q[6:0], 1'b0};
            end
          end
        endcase
      end
    end
  end

  // register store behind the pointer  (see [RULE_04])
  always_ff @(posedge i_lclk) begin
    if (!i_lrst_n) begin
      for (int i = 0; i < TSP_NREG; i++)
        regs_q[i] <= TSP_REG_RST;
    end else if (push) begin
      regs_q[ptr_q[TSP_IDX_W-1:0]] <= rx_q;  // see [RULE_15]
    end
  end

  // ************************************************************
  // alert pin: set on change, cleared by reading status
  // ************************************************************
  always_ff @(posedge i_lclk) begin
    if (!i_lrst_n) begin
      stat_q       <= 3'h0;
      alert_q      <= 1'b0;
      alert_oe_n_q <= 1'b1;
    end else begin
      stat_q <= stat_now;
      if (stat_now != stat_q)
        alert_q <= 1'b1;                   // set wins over clear
      else if (scl_fall && cnt_q == TSP_CNT_ACK && state_q == D_RDATA &&
               ptr_q == TSP_STATUS_REG)
        alert_q <= 1'b0;
      alert_oe_n_q <= ~(alert_q & aen_s_q);  // see [RULE_10]
    end
  end

  assign link.dev_sda_oe_n   = sda_oe_n_q;   // see [RULE_02]
  assign link.dev_alert_oe_n = alert_oe_n_q;

  // ************************************************************
  // written bytes stream to the user side
  // ************************************************************
  tsp_fifo #(
    .W     (TSP_FIFO_W),
    .DEPTH (TSP_FIFO_DEPTH)
  ) u_fifo (
    .i_wclk   (i_lclk),
    .i_wrst_n (i_lrst_n),
    .i_valid  (push),
    .o_ready  (fifo_ready),
    .i_data   ({ptr_q, rx_q}),
    .i_rclk   (i_mclk),
    .i_rrst_n (i_rst_n),
    .o_valid  (o_wr_valid),
    .i_ready  (i_wr_ready),
    .o_data   (fifo_out)
  );

  assign o_wr_addr = fifo_out[15:8];
  assign o_wr_data = fifo_out[7:0];
endmodule

// [src/tsp_host.sv]
// two-wire master end that talks to the touch sensor port
// assumes a command port on i_mclk; it makes the bus clock itself
module tsp_host
  import tsp_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  tsp_link_if.host        link,
  input  wire logic       i_cmd_valid,
  input  wire logic       i_cmd_write,
  input  wire logic [7:0] i_cmd_reg,
  input  wire logic [7:0] i_cmd_data,
  output logic            o_busy,
  output logic            o_done,
  output logic            o_nack,
  output logic      [7:0] o_rd_data,
  output logic            o_alert
);
  tsp_host_state_t state_q;
  logic [6:0] qcnt_q;
  logic [1:0] ph_q, step_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q, reg_q, dat_q;
  logic       wr_q, scl_oe_n_q, sda_oe_n_q;
  logic       sda_m_q, sda_s_q, al_m_q, al_s_q;
  logic       tick, rx, last;

  // byte sent in steps 0 to 2, step 3 receives  (see [RULE_04])
  function automatic logic [7:0] step_byte(input logic [1:0] s);
    unique case (s)
      2'd0:    return {TSP_SLAVE_ADDR, 1'b0};          // see [RULE_14]
      2'd1:    return reg_q;
      default: return wr_q ? dat_q : {TSP_SLAVE_ADDR, 1'b1};
    endcase
  endfunction

  assign tick = qcnt_q == TSP_QTR_LAST;   // see [RULE_12]
  assign rx   = step_q == 2'd3;
  assign last = wr_q ? (step_q == 2'd2) : rx;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      al_m_q  <= 1'b1;
      al_s_q  <= 1'b1;
      o_alert <= 1'b0;
    end else begin
      sda_m_q <= link.sda;
      sda_s_q <= sda_m_q;
      al_m_q  <= link.alert_n;
      al_s_q  <= al_m_q;
      o_alert <= ~al_s_q;
    end
  end

  // quarter bit divider, runs only during a transfer
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || state_q == H_IDLE || tick)
      qcnt_q <= 7'h00;
    else
      qcnt_q <= qcnt_q + 7'h01;
  end

  // ************************************************************
  // transfer sequencer, four quarters per bit  (see [RULE_01])
  // ************************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_q    <= H_IDLE;
      ph_q       <= 2'd0;
      step_q     <= 2'd0;
      bit_q      <= 4'h0;
      shift_q    <= 8'h00;
      reg_q      <= 8'h00;
      dat_q      <= 8'h00;
      wr_q       <= 1'b0;
      scl_oe_n_q <= 1'b1;                 // see [RULE_05]
      sda_oe_n_q <= 1'b1;
      o_busy     <= 1'b0;
      o_done     <= 1'b0;
      o_nack     <= 1'b0;
      o_rd_data  <= 8'h00;
    end else begin
      o_done <= 1'b0;
      if (state_q == H_IDLE) begin
        if (i_cmd_valid) begin
          state_q <= H_START;
          ph_q    <= 2'd0;
          step_q  <= 2'd0;
          reg_q   <= i_cmd_reg;
          dat_q   <= i_cmd_data;
          wr_q    <= i_cmd_write;
          o_busy  <= 1'b1;
          o_nack  <= 1'b0;
        end
      end else if (tick) begin
        ph_q <= ph_q + 2'd1;
        unique case (state_q)
          H_START: begin
            unique case (ph_q)
              2'd0: sda_oe_n_q <= 1'b1;
              2'd1: scl_oe_n_q <= 1'b1;
              2'd2: sda_oe_n_q <= 1'b0;   // see [RULE_06]
              2'd3: begin
                scl_oe_n_q <= 1'b0;
                state_q    <= H_BITS;
                bit_q      <= 4'h0;
                shift_q    <= step_byte(step_q);
              end
            endcase
          end
          H_BITS: begin
            unique case (ph_q)
              // data set only while the clock is low  (see [RULE_09])
              2'd0: sda_oe_n_q <= (bit_q == TSP_CNT_ACK) | rx | shift_q[7];
              2'd1: scl_oe_n_q <= 1'b1;
              2'd2: begin
                if (bit_q != TSP_CNT_ACK)
                  shift_q <= {shift_q[6:0], sda_s_q}; // see [RULE_08]
                else if (!rx && sda_s_q)
                  o_nack <= 1'b1;         // see [RULE_13]
              end
              2'd3: begin
                scl_oe_n_q <= 1'b0;
                if (bit_q != TSP_CNT_ACK) begin
                  bit_q <= bit_q + 4'h1;
                end else if (o_nack || last) begin
                  state_q <= H_STOP;
                  if (rx)
                    o_rd_data <= shift_q;
                end else if (step_q == 2'd1 && !wr_q) begin
                  step_q  <= 2'd2;         // repeated start to read
                  state_q <= H_START;
                end else begin
                  step_q  <= step_q + 2'd1;
                  bit_q   <= 4'h0;
                  shift_q <= step_byte(step_q + 2'd1);
                end
              end
            endcase
          end
          H_STOP: begin
            unique case (ph_q)
              2'd0: sda_oe_n_q <= 1'b0;
              2'd1: scl_oe_n_q <= 1'b1;
              2'd2: sda_oe_n_q <= 1'b1;   // see [RULE_07]
              2'd3: begin
                state_q <= H_IDLE;
                o_busy  <= 1'b0;
                o_done  <= 1'b1;
              end
            endcase
          end
        endcase
      end
    end
  end

  assign link.host_scl_oe_n = scl_oe_n_q;
  assign link.host_sda_oe_n = sda_oe_n_q;
endmodule

// [verification/testbench.sv]
// bench joining host and device ends over the two-wire link
// assumes both ends, the link and the checker
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic       i_mclk;
  logic       i_lclk;
  logic       i_rst_n;
  logic       i_lrst_n;
  logic       cmd_valid;
  logic       cmd_write;
  logic [7:0] cmd_reg;
  logic [7:0] cmd_data;
  logic       busy;
  logic       done;
  logic       nack;
  logic [7:0] rd_data;
  logic       alert;
  logic [2:0] pad;
  logic       alert_en;
  logic       wr_valid;
  logic       wr_ready;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  int         errors;
  int         check_count;

  tsp_link_if link ();

  // ************************************************************
  // clocks, link reset and the two ends
  // ************************************************************
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  initial begin
    i_lclk = 1'b0;
    #1.3;
    forever #3 i_lclk = ~i_lclk;
  end
  // link reset retimed to its clock
  always @(posedge i_lclk) i_lrst_n <= i_rst_n;

  tsp_device tsp_device_i (
    .i_mclk       (i_mclk),
    .i_rst_n      (i_rst_n),
    .i_lclk       (i_lclk),
    .i_lrst_n     (i_lrst_n),
    .link         (link),
    .i_pad_status (pad),
    .i_alert_en   (alert_en),
    .o_wr_valid   (wr_valid),
    .i_wr_ready   (wr_ready),
    .o_wr_addr    (wr_addr),
    .o_wr_data    (wr_data)
  );
  tsp_host tsp_host_i (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .link        (link),
    .i_cmd_valid (cmd_valid),
    .i_cmd_write (cmd_write),
    .i_cmd_reg   (cmd_reg),
    .i_cmd_data  (cmd_data),
    .o_busy      (busy),
    .o_done      (done),
    .o_nack      (nack),
    .o_rd_data   (rd_data),
    .o_alert     (alert)
  );
  tsp_link_properties tsp_link_properties_i (
    .i_lclk        (i_lclk),
    .i_lrst_n      (i_lrst_n),
    .host_sda_oe_n (link.host_sda_oe_n),
    .dev_sda_oe_n  (link.dev_sda_oe_n),
    .scl           (link.scl),
    .sda           (link.sda)
  );

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one host command, started by the host
  task automatic xfer(input logic wr, input logic [7:0] rg,
                      input logic [7:0] dt);
    int n;
    @(posedge i_mclk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_reg   <= rg;
    cmd_data  <= dt;
    @(posedge i_mclk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge i_mclk);
      n++;
    end while (done !== 1'b1 && n < 20000);
    chk("busy_done_nack", {13'h0, busy, done, nack}, 16'h2);
  endtask

  // takes one stream word
  task automatic pop(input logic [15:0] exp);
    int n;
    n = 0;
    while (wr_valid !== 1'b1 && n < 100) begin
      @(negedge i_mclk);
      n++;
    end
    chk("word", {wr_addr, wr_data}, exp);
    @(negedge i_mclk);
  endtask

  task automatic wait_alert(input logic v);
    int n;
    n = 0;
    while (alert !== v && n < 60) begin
      @(negedge i_mclk);
      n++;
    end
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    i_rst_n     = 1'b0;
    cmd_valid   = 1'b0;
    cmd_write   = 1'b0;
    cmd_reg     = 8'h00;
    cmd_data    = 8'h00;
    pad         = 3'h0;
    alert_en    = 1'b0;
    wr_ready    = 1'b0;
    errors      = 0;
    check_count = 0;
    repeat (16) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (8) @(negedge i_mclk);
    chk("idle", {11'h0, link.scl, link.sda, alert, nack, wr_valid},
        16'h0018);
    // three writes queue in the stalled buffer
    xfer(1'b1, 8'h03, 8'ha5);
    xfer(1'b1, 8'h0f, 8'h5a);
    xfer(1'b1, 8'h00, 8'h3c);
    chk("stall", {15'h0, wr_valid}, 16'h1);
    @(posedge i_mclk);
    wr_ready <= 1'b1;
    @(negedge i_mclk);
    pop(16'h03a5);
    pop(16'h0f5a);
    pop(16'h003c);
    chk("empty", {15'h0, wr_valid}, 16'h0);
    // reads go through a repeated start
    xfer(1'b0, 8'h03, 8'h00);
    chk("rd03", {8'h0, rd_data}, 16'h00a5);
    xfer(1'b0, 8'h0f, 8'h00);
    chk("rd0f", {8'h0, rd_data}, 16'h005a);
    // alert set by a pad change, cleared by a status read
    @(posedge i_mclk);
    alert_en <= 1'b1;
    pad      <= 3'h7;
    wait_alert(1'b1);
    chk("alert", {14'h0, alert, link.alert_n}, 16'h2);
    xfer(1'b0, 8'h00, 8'h00);
    chk("pads2", {8'h0, rd_data}, 16'h0003);
    wait_alert(1'b0);
    chk("clear", {14'h0, alert, link.alert_n}, 16'h1);
    // alert off: third pad counts
    @(posedge i_mclk);
    alert_en <= 1'b0;
    pad      <= 3'h5;
    wait_alert(1'b1);
    chk("masked", {14'h0, alert, link.alert_n}, 16'h1);
    xfer(1'b0, 8'h00, 8'h00);
    chk("pads3", {8'h0, rd_data}, 16'h0005);
    give_verdict();
  end

  // watchdog on a hang
  initial begin
    repeat (95000) @(posedge i_mclk);
    errors++;
    give_verdict();
  end
endmodule

// [verification/tsp_link_properties.sv]
// link checker: framing, acknowledge and bit timing on the two wires
// assumes the link signals, sampled on the link clock
module tsp_link_properties
  import tsp_pkg::*;
(
  input wire logic i_lclk,
  input wire logic i_lrst_n,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking @(posedge i_lclk); endclocking
  default disable iff (!i_lrst_n);

  // ************************************************************
  // bus event tracking
  // ************************************************************
  logic       scl_q;
  logic       sda_q;
  logic [3:0] cnt_q;
  logic [1:0] byt_q;
  logic [7:0] sh_q;
  logic       rd_q;
  logic [8:0] per_q;
  logic       start;
  logic       stop;
  logic       rise;

  // line events
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop  = scl & scl_q & ~sda_q & sda;
  assign rise  = scl & ~scl_q;

  // previous line levels
  always_ff @(posedge i_lclk) begin
    scl_q <= i_lrst_n ? scl : 1'b1;
    sda_q <= i_lrst_n ? sda : 1'b1;
  end

  // pulses in the byte, bytes since start
  always_ff @(posedge i_lclk) begin
    if (!i_lrst_n || start) begin
      cnt_q <= 4'h0;
      byt_q <= 2'h0;
    end else if (rise) begin
      cnt_q <= (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
      if (cnt_q == 4'h9 && byt_q != 2'h3) begin
        byt_q <= byt_q + 2'h1;
      end
    end
  end

  // shifted bits and direction
  always_ff @(posedge i_lclk) begin
    if (!i_lrst_n) begin
      sh_q <= 8'h00;
      rd_q <= 1'b0;
    end else if (rise) begin
      sh_q <= {sh_q[6:0], sda};
      if (cnt_q == 4'h8 && byt_q == 2'h0) begin
        rd_q <= sh_q[0];
      end
    end
  end

  // link cycles since the last clock rise, saturating
  always_ff @(posedge i_lclk) begin
    if (!i_lrst_n) begin
      per_q <= 9'h1ff;
    end else if (rise) begin
      per_q <= 9'h000;
    end else if (per_q != 9'h1ff) begin
      per_q <= per_q + 9'h001;
    end
  end

  // ************************************************************
  // properties
  // ************************************************************
  property p_dev_hold;
    scl && scl_q |-> $stable(dev_sda_oe_n);
  endproperty
  a_dev_hold: assert property (p_dev_hold)
    else $error("device data moved in clock high");
  property p_stop_free;
    stop |=> dev_sda_oe_n [*4];
  endproperty
  a_stop_free: assert property (p_stop_free)
    else $error("device pulls data after stop");
  property p_addr_quiet;
    byt_q == 2'h0 && cnt_q != 4'h9 && scl && scl_q |-> dev_sda_oe_n;
  endproperty
  a_addr_quiet: assert property (p_addr_quiet)
    else $error("device drives in address");
  property p_addr_ack;
    rise && cnt_q == 4'h8 && byt_q == 2'h0
    |-> !dev_sda_oe_n == (sh_q[7:1] == TSP_SLAVE_ADDR);
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("address acknowledge wrong");
  property p_wr_ack;
    rise && cnt_q == 4'h8 && byt_q != 2'h0 && !rd_q |-> !dev_sda_oe_n;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("written byte not acknowledged");
  property p_wr_quiet;
    rise && cnt_q < 4'h8 && byt_q != 2'h0 && !rd_q |-> dev_sda_oe_n;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet)
    else $error("device drives in written bits");
  property p_rd_free;
    rise && cnt_q < 4'h8 && byt_q != 2'h0 && rd_q |-> host_sda_oe_n;
  endproperty
  a_rd_free: assert property (p_rd_free)
    else $error("host drives in read bits");
  property p_rd_ack;
    rise && cnt_q == 4'h8 && byt_q != 2'h0 && rd_q |-> dev_sda_oe_n;
  endproperty
  a_rd_ack: assert property (p_rd_ack)
    else $error("device holds host acknowledge");
  // a bit lasts at least 2500 ns, 416 link cycles
  property p_rate;
    rise |-> per_q >= 9'h1a0;
  endproperty
  a_rate: assert property (p_rate)
    else $error("clock pulses too close");

  // main scenarios
  c_write: cover property (rise && cnt_q == 4'h8 && byt_q == 2'h2 && !rd_q);
  c_read: cover property (rise && cnt_q == 4'h8 && byt_q == 2'h1 && rd_q);
  c_rstart: cover property (start && byt_q != 2'h0);
endmodule
